// file: common/lcdcps_pkg.sv
// package for the lcd common pin select block
package lcdcps_pkg;

   // ****************************************************
   // register map
   // ****************************************************
   localparam logic [3:0] CTRL_ADDR   = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam logic [7:0] CTRL_RESET  = 8'h00;

   // ****************************************************
   // field positions of the control register
   // ****************************************************
   localparam int RSVD_BIT   = 7;
   localparam int ISEL_HI    = 6;
   localparam int ISEL_LO    = 5;
   localparam int MASTER_BIT = 4;
   localparam int SEL3_BIT   = 3;
   localparam int SEL2_BIT   = 2;
   localparam int SEL1_BIT   = 1;
   localparam int SEL0_BIT   = 0;

   // ****************************************************
   // bus answers
   // ****************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic        aw_held;
      logic [3:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } lcdcps_state_t;

endpackage : lcdcps_pkg

// file: src/lcdcps_top.sv
// lcd common pin select: control register, pin steering and axi4-lite slave

// Notes on behaviour
// - master enable off keeps all pins GPIO
// - common function needs master and pin select
// - bit 3 routes portc_line6 to common 3
// - bit 2 routes portc_line7 to common 2
// - bit 1 routes portb_line7 to common 1
// - bit 0 routes portb_line6 to common 0
// - bits 6:5 give drive current code
// - common pins drive regardless of port direction
module lcdcps_top
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // gpio side of the four shared pins: order portb_line6, portb_line7, portc_line7, portc_line6
   input  wire logic [3:0]  gpio_out,
   input  wire logic [3:0]  gpio_oe,
   // lcd common levels from the application, same order
   input  wire logic [3:0]  lcd_common_out,
   // pad side
   output logic [3:0]       pad_out,
   output logic [3:0]       pad_oe,
   output logic [3:0]       pad_is_common,
   // analog half-supply driver
   output logic [1:0]       drive_current_sel,
   output logic             lcd_common_master_en
);

   lcdcps_pkg::lcdcps_state_t st_reg;
   lcdcps_pkg::lcdcps_state_t st_next;

   logic       wr_fire;
   logic [3:0] sel;
   logic [3:0] common_on;

   assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
   assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;

   // ****************************************************
   // register and bus state
   // ****************************************************
   always_comb
   begin
      st_next = st_reg;
      if (s_axi_awvalid && s_axi_awready)
      begin
         st_next.aw_held = 1'h1;
         // only the low address bits decode, so the map repeats every 16 bytes
         st_next.aw_addr = s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         st_next.w_held = 1'h1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      wr_fire = st_next.aw_held && st_next.w_held && !st_reg.bvalid;
      if (wr_fire)
      begin
         st_next.aw_held = 1'h0;
         st_next.w_held  = 1'h0;
         st_next.bvalid  = 1'h1;
         st_next.bresp   = lcdcps_pkg::RESP_OKAY;
         if (st_next.aw_addr == lcdcps_pkg::CTRL_ADDR)
         begin
            // full byte writable
            // bit 7 is stored as written; keeping it zero is up to software
            if (st_next.w_strb[0])
               st_next.ctrl = st_next.w_data[7:0];
         end
         else if (st_next.aw_addr != lcdcps_pkg::STATUS_ADDR)
            st_next.bresp = lcdcps_pkg::RESP_SLVERR;
      end
      else if (st_reg.bvalid && s_axi_bready)
         st_next.bvalid = 1'h0;

      if (st_reg.rvalid && s_axi_rready)
         st_next.rvalid = 1'h0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         st_next.rvalid = 1'h1;
         st_next.rresp  = lcdcps_pkg::RESP_OKAY;
         st_next.rdata  = 32'h0000_0000;
         if (s_axi_araddr[3:0] == lcdcps_pkg::CTRL_ADDR)
            st_next.rdata = {24'h00_0000, st_reg.ctrl};
         else if (s_axi_araddr[3:0] == lcdcps_pkg::STATUS_ADDR)
            st_next.rdata = {28'h000_0000, common_on};
         else
            st_next.rresp = lcdcps_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg      <= '0;
         st_reg.ctrl <= lcdcps_pkg::CTRL_RESET;
      end
      else
         st_reg <= st_next;
   end

   // ****************************************************
   // pin steering
   // ****************************************************
   assign sel = {st_reg.ctrl[lcdcps_pkg::SEL3_BIT], st_reg.ctrl[lcdcps_pkg::SEL2_BIT],
                 st_reg.ctrl[lcdcps_pkg::SEL1_BIT], st_reg.ctrl[lcdcps_pkg::SEL0_BIT]};
   assign lcd_common_master_en = st_reg.ctrl[lcdcps_pkg::MASTER_BIT];
   assign drive_current_sel = st_reg.ctrl[lcdcps_pkg::ISEL_HI:lcdcps_pkg::ISEL_LO];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_pin
         assign common_on[gi] = lcd_common_master_en && sel[gi];
         assign pad_oe[gi]  = common_on[gi] ? 1'h1 : gpio_oe[gi];
         assign pad_out[gi] = common_on[gi] ? lcd_common_out[gi] : gpio_out[gi];
         assign pad_is_common[gi] = common_on[gi];
      end
   endgenerate

   // ****************************************************
   // checks
   // ****************************************************
   sequence s_ctrl_write;
      wr_fire && st_next.aw_addr == lcdcps_pkg::CTRL_ADDR && st_next.w_strb[0];
   endsequence
   AST_MASTER_OFF_GPIO: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_reg.ctrl[lcdcps_pkg::MASTER_BIT] |->
      (pad_is_common == 4'h0 && pad_out == gpio_out && pad_oe == gpio_oe))
      else $error("pin taken from gpio with master off");
   AST_BOTH_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
      pad_is_common == (st_reg.ctrl[3:0] & {4{st_reg.ctrl[4]}}))
      else $error("common function mismatch");
   AST_PC6_COM3: assert property (@(posedge aclk) disable iff (!aresetn)
      pad_is_common[3] |-> (pad_out[3] == lcd_common_out[3]))
      else $error("port c line 6 not on common 3");
   AST_PC7_COM2: assert property (@(posedge aclk) disable iff (!aresetn)
      !pad_is_common[2] |-> (pad_out[2] == gpio_out[2]))
      else $error("port c line 7 not gpio");
   AST_PB7_COM1: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pad_is_common[1]) |-> $past(st_next.ctrl[1]))
      else $error("port b line 7 selected without bit");
   AST_PB6_COM0: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_reg.ctrl[4] && st_reg.ctrl[0]) |-> pad_is_common[0])
      else $error("port b line 6 not on common 0");
   AST_CURRENT: assert property (@(posedge aclk) disable iff (!aresetn)
      s_ctrl_write |=> (drive_current_sel == $past(st_next.w_data[6:5])))
      else $error("current code mismatch");
   AST_OE_FORCED: assert property (@(posedge aclk) disable iff (!aresetn)
      (pad_is_common & ~pad_oe) == 4'h0)
      else $error("common pin not driven");
   AST_WRITE_READBACK: assert property (@(posedge aclk) disable iff (!aresetn)
      s_ctrl_write |=> (st_reg.ctrl == $past(st_next.w_data[7:0])))
      else $error("control write lost");

   // ****************************************************
   // bus answer checks
   // ****************************************************
   sequence s_write_taken;
      wr_fire;
   endsequence
   sequence s_read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
      s_write_taken |=> s_axi_bvalid)
      else $error("write taken without answer");
   AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
      s_read_taken |=> (s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000))
      else $error("read taken without answer");
   AST_CTRL_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_read_taken && s_axi_araddr[3:0] == lcdcps_pkg::CTRL_ADDR)
      |=> (s_axi_rdata[7:0] == $past(st_reg.ctrl)))
      else $error("control read back wrong");
   AST_STATUS_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_read_taken && s_axi_araddr[3:0] == lcdcps_pkg::STATUS_ADDR)
      |=> (s_axi_rdata[3:0] == $past(pad_is_common)))
      else $error("status read back wrong");
   // an answer is single-shot: a second beat would be taken as a new transfer
   AST_BVALID_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
      else $error("write answer repeated");
   AST_RVALID_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
      else $error("read answer repeated");
   AST_RESET_CLEAR: assert property (@(posedge aclk)
      $rose(aresetn) |->
      (st_reg.ctrl == lcdcps_pkg::CTRL_RESET && !s_axi_bvalid && !s_axi_rvalid))
      else $error("state not cleared by reset");

endmodule // lcdcps_top

// file: bench/lcdcps_panel.sv
// lcd panel model: level each common electrode sees on the four shared pads
module lcdcps_panel
(
   // pads
   input  wire logic [3:0] pad_out,
   input  wire logic [3:0] pad_oe,
   // electrode level
   output logic      [3:0] seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] last = 4'h0;
   // an undriven pad has no pull, so show the inverse of its last driven level
   always @(pad_out, pad_oe)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (pad_oe[i])
            last[i] = pad_out[i];
         seen[i] = pad_oe[i] ? pad_out[i] : ~last[i];
      end
   end
endmodule // lcdcps_panel

// file: bench/lcdcps_top_tb.sv
// self-checking bench for the lcd common pin select block
module lcdcps_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [31:0] s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'h0, gpio_out = 4'hA, gpio_oe = 4'h6, lcd_common_out = 4'h5;
   logic [3:0]  pad_out, pad_oe, pad_is_common, seen;
   logic [1:0]  s_axi_bresp, s_axi_rresp, drive_current_sel, r;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        lcd_common_master_en;
   int          fails = 0, checks = 0, cyc = 0;
   // bit 7 is never set: software keeps it clear
   logic [7:0]  tbl [9] = '{8'h0F, 8'h10, 8'h18, 8'h14, 8'h12, 8'h11, 8'h3F, 8'h5F, 8'h7F};

   lcdcps_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_out, .gpio_oe, .lcd_common_out,
      .pad_out, .pad_oe, .pad_is_common, .drive_current_sel, .lcd_common_master_en);
   lcdcps_panel panel_u (.pad_out, .pad_oe, .seen);

   always #5 aclk = ~aclk;

   // ************************************
   // bus tasks and compare
   // ************************************
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // ready is sampled at the falling edge, where it equals what the next rising edge sees
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, tb;
      tb = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!tb)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'h0;
         if (tw)
            s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
   endtask

   task automatic rdr(input logic [31:0] a);
      logic ta, tr;
      tr = 1'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!tr)
      begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         rd = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta)
            s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
   endtask

   task automatic pins(input logic [7:0] v);
      logic [3:0] c;
      c = v[4] ? v[3:0] : 4'h0;
      @(negedge aclk);
      chk({19'h0, drive_current_sel, lcd_common_master_en, pad_is_common, pad_oe, pad_out},
          {19'h0, v[6:5], v[4], c, gpio_oe | c, (gpio_out & ~c) | (lcd_common_out & c)});
      // the panel must see the common level even where the port leaves the pad undriven
      chk({30'h0, seen & c}, {30'h0, lcd_common_out & c});
      @(posedge aclk);
   endtask

   task automatic end_of_test();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ************************************
   // sequence and hang guard
   // ************************************
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rdr(32'h0);
      chk({r, rd}, {lcdcps_pkg::RESP_OKAY, 32'h0});
      pins(8'h00);
      foreach (tbl[i])
      begin
         // swap port and panel levels each pass so both pad sources are exercised
         gpio_out <= ~gpio_out;
         gpio_oe <= ~gpio_oe;
         lcd_common_out <= ~lcd_common_out;
         wr(32'h0, {24'h0, tbl[i]}, 4'hF);
         rdr(32'h0);
         chk({r, rd}, {lcdcps_pkg::RESP_OKAY, 24'h0, tbl[i]});
         pins(tbl[i]);
      end
      wr(32'h0, 32'h1, 4'hE);
      rdr(32'h4);
      chk({r, rd}, {lcdcps_pkg::RESP_OKAY, 32'hF});
      wr(32'h8, 32'h0, 4'hF);
      chk({r, 32'h0}, {lcdcps_pkg::RESP_SLVERR, 32'h0});
      rdr(32'h8);
      chk({r, rd}, {lcdcps_pkg::RESP_SLVERR, 32'h0});
      wr(32'h4, 32'h0, 4'hF);
      chk({r, 32'h0}, {lcdcps_pkg::RESP_OKAY, 32'h0});
      rdr(32'h0);
      chk({r, rd}, {lcdcps_pkg::RESP_OKAY, 32'h7F});
      wr(32'h0, 32'h0, 4'hF);
      pins(8'h00);
      end_of_test();
   end
endmodule // lcdcps_top_tb
